// ### bench/tb_deep_sleep_exit_control.sv
// Self-checking testbench for the deep sleep exit controller.
`timescale 1ns/100ps
`default_nettype none
module tb_deep_sleep_exit_control;
	logic clock, rst, psel, penable, pwrite, pready, pslverr, interrupt_pending, err;
	logic core_reset, interrupts_flush, secondary_oscillator_run, deep_sleep_active;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] pin_in, pin_out, pin_oe;
	deep_sleep_exit_pkg::wake_in_type wake_in;
	int n_fail, samples_checked, n_flush, flush0, len;
	// Control config, wake stimulus, wake flags (zero means ignored, then master clear), brown-out flag.
	typedef struct packed {logic [15:0] cfg; logic [5:0] stim; logic [4:0] flags; logic bo;} row_type;
	row_type rows [7] = '{
		'{16'h0020, 6'h24, 5'h01, 1'h0},
		'{16'h0000, 6'h14, 5'h02, 1'h0},
		'{16'h0024, 6'h0c, 5'h04, 1'h0},
		'{16'h0000, 6'h0c, 5'h00, 1'h0},
		'{16'h0018, 6'h06, 5'h10, 1'h0},
		'{16'h0010, 6'h06, 5'h00, 1'h0},
		'{16'h0000, 6'h05, 5'h00, 1'h1}};

	deep_sleep_exit_control deep_sleep_exit_control_inst (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wake_in(wake_in), .interrupt_pending(interrupt_pending), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .core_reset(core_reset), .interrupts_flush(interrupts_flush),
		.secondary_oscillator_run(secondary_oscillator_run), .deep_sleep_active(deep_sleep_active));

	initial
	begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock)
		if (interrupts_flush === 1'h1) n_flush++;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A held transfer keeps psel up so that the next setup follows at once.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic hold);
		int i;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		i = 0;
		do
		begin
			@(posedge clock);
			i++;
		end
		while (pready !== 1'h1 && i < 20);
		rd = prdata;
		err = pslverr;
		if (i >= 20) n_fail++;
		if (!hold)
		begin
			psel <= 1'h0;
			penable <= 1'h0;
			@(posedge clock);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		#100000;
		n_fail++;
		test_done();
	end

	initial
	begin
		rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		wake_in = 6'h04;
		interrupt_pending = 1'h1;
		pin_in = 16'h1234;
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		@(posedge clock);
		apb(1'h0, deep_sleep_exit_pkg::status_offset, 32'h0, 1'h0);
		check(rd, 32'h00012341);
		apb(1'h0, deep_sleep_exit_pkg::ctrl_offset, 32'h0, 1'h0);
		check(rd, 32'h00000000);
		apb(1'h0, 12'h020, 32'h0, 1'h0);
		check({err, rd[30:0]}, 32'h80000000);
		apb(1'h1, deep_sleep_exit_pkg::scratch0_offset, 32'hdeadbeef, 1'h0);
		apb(1'h1, deep_sleep_exit_pkg::scratch1_offset, 32'h0badf00d, 1'h0);
		foreach (rows[k])
		begin
			apb(1'h1, deep_sleep_exit_pkg::pin_dir_offset, 32'h0000ff00, 1'h0);
			apb(1'h1, deep_sleep_exit_pkg::pin_lat_offset, 32'h0000a5a5, 1'h0);
			flush0 = n_flush;
			apb(1'h1, deep_sleep_exit_pkg::ctrl_offset, {16'h0000, 16'h8000 | rows[k].cfg}, 1'h1);
			apb(1'h1, deep_sleep_exit_pkg::ctrl_offset, {16'h0000, 16'h8040 | rows[k].cfg}, 1'h0);
			apb(1'h1, deep_sleep_exit_pkg::pin_lat_offset, 32'h00000000, 1'h0);
			check(32'(deep_sleep_active), 32'h1);
			check(32'(n_flush - flush0), 32'h1);
			check(32'(secondary_oscillator_run), 32'(rows[k].cfg[5]));
			check(32'(pin_oe), 32'h000000ff);
			check(32'(pin_out & 16'h00ff), 32'h000000a5);
			wake_in <= rows[k].stim;
			if (rows[k].flags == 5'h00)
			begin
				repeat (10) @(posedge clock);
				check(32'(deep_sleep_active), 32'h1);
				wake_in <= 6'h00;
			end
			for (int i = 0; i < 20 && core_reset !== 1'h1; i++) @(posedge clock);
			wake_in <= 6'h0c;
			len = 0;
			while (core_reset === 1'h1 && len < 100)
			begin
				@(posedge clock);
				len++;
			end
			check(32'(len), 32'(deep_sleep_exit_pkg::reset_seq_cycles));
			wake_in <= 6'h04;
			apb(1'h0, deep_sleep_exit_pkg::wake_offset, 32'h0, 1'h0);
			check(rd, 32'(rows[k].flags == 5'h00 ? 5'h08 : rows[k].flags));
			apb(1'h0, deep_sleep_exit_pkg::reset_ctrl_offset, 32'h0, 1'h0);
			check(rd & 32'h00000400, 32'h00000400);
			apb(1'h0, deep_sleep_exit_pkg::ctrl_offset, 32'h0, 1'h0);
			check(rd & 32'h00008003, 32'({rows[k].bo, 1'h1}));
			apb(1'h0, deep_sleep_exit_pkg::scratch0_offset, 32'h0, 1'h0);
			check(rd, 32'hdeadbeef);
			apb(1'h0, deep_sleep_exit_pkg::scratch1_offset, 32'h0, 1'h0);
			check(rd, 32'h0badf00d);
			check(32'(pin_oe), 32'h000000ff);
			apb(1'h1, deep_sleep_exit_pkg::ctrl_offset, 32'h0, 1'h0);
			apb(1'h1, deep_sleep_exit_pkg::reset_ctrl_offset, 32'h0, 1'h0);
			apb(1'h0, deep_sleep_exit_pkg::reset_ctrl_offset, 32'h0, 1'h0);
			check(rd & 32'h00000400, 32'h0);
			check(32'(pin_oe), 32'h0);
			apb(1'h0, deep_sleep_exit_pkg::status_offset, 32'h0, 1'h0);
			check(rd, 32'h00012341);
			// Re-arming too soon after unfreeze is illegal, so leave a gap.
			repeat (4) @(posedge clock);
		end
		apb(1'h1, deep_sleep_exit_pkg::ctrl_offset, 32'h00008000, 1'h0);
		// A quiet bus lets the arm window run out untouched.
		repeat (4) @(posedge clock);
		apb(1'h0, deep_sleep_exit_pkg::wake_offset, 32'h0, 1'h0);
		check(rd, 32'h0);
		apb(1'h0, deep_sleep_exit_pkg::ctrl_offset, 32'h0, 1'h0);
		check(rd & 32'h00008000, 32'h0);
		apb(1'h1, deep_sleep_exit_pkg::ctrl_offset, 32'h00000040, 1'h0);
		repeat (2) @(posedge clock);
		check(32'(deep_sleep_active), 32'h0);
		test_done();
	end
endmodule // tb_deep_sleep_exit_control
`default_nettype wire

// ### verilog/deep_sleep_exit_control.sv
// Deep sleep entry, wake and exit control with APB registers and pin freeze.
`timescale 1ns/100ps
`default_nettype none
module deep_sleep_exit_control
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Wake sources.
	input wire deep_sleep_exit_pkg::wake_in_type wake_in,
	input wire logic interrupt_pending,
	// Pins and core control.
	input wire logic [15:0] pin_in,
	output logic [15:0] pin_out,
	output logic [15:0] pin_oe,
	output logic core_reset,
	output logic interrupts_flush,
	output logic secondary_oscillator_run,
	output logic deep_sleep_active
);
	deep_sleep_exit_pkg::state_type state_reg;
	logic [15:0] ctrl_reg;
	logic [deep_sleep_exit_pkg::wake_width-1:0] wake_reg;
	logic exit_flag_reg;
	logic [31:0] scratch0_reg;
	logic [31:0] scratch1_reg;
	logic [15:0] dir_reg;
	logic [15:0] lat_reg;
	logic [1:0] arm_count_reg;
	logic [7:0] seq_count_reg;
	logic external_interrupt_zero_prev_reg;
	logic [deep_sleep_exit_pkg::wake_width-1:0] wake_next;
	logic wr;
	logic rd;
	logic sleeping;
	logic frozen;
	logic external_interrupt_zero_en;
	logic external_interrupt_zero_pol;
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign sleeping = state_reg == deep_sleep_exit_pkg::st_sleep;
	assign frozen = state_reg != deep_sleep_exit_pkg::st_run;
	assign external_interrupt_zero_en = ctrl_reg[deep_sleep_exit_pkg::external_interrupt_zero_enable_bit];
	assign external_interrupt_zero_pol = ctrl_reg[deep_sleep_exit_pkg::external_interrupt_zero_polarity_bit];

	always_comb
	begin
		wake_next = '0;
		wake_next[deep_sleep_exit_pkg::wake_por_bit] = wake_in.por;
		wake_next[deep_sleep_exit_pkg::wake_wdt_bit] = wake_in.wdt_timeout;
		wake_next[deep_sleep_exit_pkg::wake_alarm_bit] = wake_in.alarm
			&& ctrl_reg[deep_sleep_exit_pkg::calendar_enable_bit];
		wake_next[deep_sleep_exit_pkg::wake_master_clear_pin_bit] = !wake_in.master_clear_pin_n;
		// A level already at the wake polarity on entry counts as a change and wakes at once.
		wake_next[deep_sleep_exit_pkg::wake_external_interrupt_zero_bit] = external_interrupt_zero_en && (wake_in.external_interrupt_zero_level == external_interrupt_zero_pol)
			&& (external_interrupt_zero_prev_reg != external_interrupt_zero_pol);
	end

	// Sleep state sequence.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_reg <= deep_sleep_exit_pkg::st_run;
			seq_count_reg <= 8'h00;
		end
		else
		begin
			unique case (state_reg)
				deep_sleep_exit_pkg::st_run:
				begin
					if (wr && paddr == deep_sleep_exit_pkg::ctrl_offset
						&& pwdata[deep_sleep_exit_pkg::sleep_cmd_bit]
						&& ctrl_reg[deep_sleep_exit_pkg::arm_bit])
						state_reg <= deep_sleep_exit_pkg::st_sleep;
				end
				deep_sleep_exit_pkg::st_sleep:
				begin
					if (|wake_next)
					begin
						state_reg <= deep_sleep_exit_pkg::st_exit;
						seq_count_reg <= 8'(deep_sleep_exit_pkg::reset_seq_cycles);
					end
				end
				deep_sleep_exit_pkg::st_exit:
				begin
					seq_count_reg <= seq_count_reg - 8'h01;
					if (seq_count_reg == 8'h01)
						state_reg <= deep_sleep_exit_pkg::st_frozen;
				end
				deep_sleep_exit_pkg::st_frozen:
				begin
					if (!ctrl_reg[deep_sleep_exit_pkg::unfreeze_bit])
						state_reg <= deep_sleep_exit_pkg::st_run;
				end
			endcase
		end
	end

	// External_interrupt_zero level history, taken only while asleep.
	always_ff @(posedge clock)
	begin
		if (rst)
			external_interrupt_zero_prev_reg <= 1'b0;
		else if (!sleeping)
			external_interrupt_zero_prev_reg <= !external_interrupt_zero_pol;
		else
			external_interrupt_zero_prev_reg <= wake_in.external_interrupt_zero_level;
	end

	// Control register; arm clears on timeout and on exit.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ctrl_reg <= 16'h0000;
			arm_count_reg <= 2'h0;
		end
		else
		begin
			if (wr && paddr == deep_sleep_exit_pkg::ctrl_offset && !frozen)
			begin
				ctrl_reg <= pwdata[15:0];
				ctrl_reg[deep_sleep_exit_pkg::brownout_bit] <= ctrl_reg[deep_sleep_exit_pkg::brownout_bit]
					& pwdata[deep_sleep_exit_pkg::brownout_bit];
				arm_count_reg <= 2'h0;
			end
			else if (wr && paddr == deep_sleep_exit_pkg::ctrl_offset)
				ctrl_reg[deep_sleep_exit_pkg::unfreeze_bit] <= pwdata[deep_sleep_exit_pkg::unfreeze_bit];
			else if (ctrl_reg[deep_sleep_exit_pkg::arm_bit] && !sleeping)
			begin
				arm_count_reg <= arm_count_reg + 2'h1;
				if (arm_count_reg == 2'(deep_sleep_exit_pkg::arm_window_cycles - 1))
					ctrl_reg[deep_sleep_exit_pkg::arm_bit] <= 1'b0;
			end
			if (sleeping && wake_in.brownout)
				ctrl_reg[deep_sleep_exit_pkg::brownout_bit] <= 1'b1;
			if (sleeping && |wake_next)
			begin
				// Freeze survives the reset-like exit until software releases it.
				ctrl_reg[deep_sleep_exit_pkg::arm_bit] <= 1'b0;
				ctrl_reg[deep_sleep_exit_pkg::unfreeze_bit] <= 1'b1;
			end
		end
	end

	// Wake flags and exit flag; exit set wins over a clearing write.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wake_reg <= '0;
			exit_flag_reg <= 1'b0;
		end
		else
		begin
			if (wr && paddr == deep_sleep_exit_pkg::ctrl_offset && pwdata[deep_sleep_exit_pkg::arm_bit])
				wake_reg <= '0;
			else if (sleeping)
				wake_reg <= wake_reg | wake_next;
			if (wr && paddr == deep_sleep_exit_pkg::reset_ctrl_offset)
				exit_flag_reg <= pwdata[deep_sleep_exit_pkg::exit_flag_bit];
			if (sleeping && |wake_next)
				exit_flag_reg <= 1'b1;
		end
	end

	// Scratch registers and pin configuration; scratch never resets on exit.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			dir_reg <= 16'hffff;
			lat_reg <= 16'h0000;
			scratch0_reg <= deep_sleep_exit_pkg::zero_word;
			scratch1_reg <= deep_sleep_exit_pkg::zero_word;
		end
		else
		begin
			if (wr && paddr == deep_sleep_exit_pkg::scratch0_offset)
				scratch0_reg <= pwdata;
			if (wr && paddr == deep_sleep_exit_pkg::scratch1_offset)
				scratch1_reg <= pwdata;
			if (wr && paddr == deep_sleep_exit_pkg::pin_dir_offset && !frozen)
				dir_reg <= pwdata[15:0];
			if (wr && paddr == deep_sleep_exit_pkg::pin_lat_offset && !frozen)
				lat_reg <= pwdata[15:0];
			// The exit is a power-on reset for the pin setup; the drivers below keep the frozen state.
			if (sleeping && |wake_next)
			begin
				dir_reg <= 16'hffff;
				lat_reg <= 16'h0000;
			end
		end
	end

	// Pin drivers hold entry state while frozen, since they update only in the run state.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pin_out <= 16'h0000;
			pin_oe <= 16'h0000;
		end
		else if (!frozen)
		begin
			// Drivers hold from entry until release, even though the exit resets the pin setup.
			pin_out <= lat_reg;
			pin_oe <= ~dir_reg;
		end
	end

	// Core side outputs.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			core_reset <= 1'b0;
			interrupts_flush <= 1'b0;
			secondary_oscillator_run <= 1'b0;
			deep_sleep_active <= 1'b0;
		end
		else
		begin
			// Exit resets the core, which restarts at its reset vector.
			core_reset <= state_reg == deep_sleep_exit_pkg::st_exit;
			interrupts_flush <= state_reg == deep_sleep_exit_pkg::st_run && wr
				&& paddr == deep_sleep_exit_pkg::ctrl_offset && pwdata[deep_sleep_exit_pkg::sleep_cmd_bit]
				&& ctrl_reg[deep_sleep_exit_pkg::arm_bit] && interrupt_pending;
			secondary_oscillator_run <= ctrl_reg[deep_sleep_exit_pkg::secondary_oscillator_enable_bit];
			deep_sleep_active <= sleeping;
		end
	end

	// APB read data and responses.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			prdata <= deep_sleep_exit_pkg::zero_word;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (rd)
			begin
				unique case (paddr)
					deep_sleep_exit_pkg::ctrl_offset: prdata <= {16'h0000, ctrl_reg};
					deep_sleep_exit_pkg::wake_offset: prdata <= {27'h0, wake_reg};
					deep_sleep_exit_pkg::reset_ctrl_offset: prdata <= {21'h0, exit_flag_reg, 10'h0};
					deep_sleep_exit_pkg::scratch0_offset: prdata <= scratch0_reg;
					deep_sleep_exit_pkg::scratch1_offset: prdata <= scratch1_reg;
					deep_sleep_exit_pkg::pin_dir_offset: prdata <= {16'h0000, dir_reg};
					deep_sleep_exit_pkg::pin_lat_offset: prdata <= {16'h0000, lat_reg};
					deep_sleep_exit_pkg::status_offset: prdata <= {12'h000, pin_in, state_reg};
					default:
					begin
						prdata <= deep_sleep_exit_pkg::zero_word;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	property p_exit_flag;
		@(posedge clock) disable iff (rst)
		(sleeping && |wake_next) |=> exit_flag_reg && !ctrl_reg[deep_sleep_exit_pkg::arm_bit];
	endproperty
	a_exit_flag: assert property (p_exit_flag)
		else $error("exit flag or arm bit wrong after wake");
	property p_arm_timeout;
		@(posedge clock) disable iff (rst)
		($rose(ctrl_reg[deep_sleep_exit_pkg::arm_bit]) && !psel) ##1 !psel [*3]
		|-> !ctrl_reg[deep_sleep_exit_pkg::arm_bit];
	endproperty
	a_arm_timeout: assert property (p_arm_timeout)
		else $error("arm bit not cleared after window");
	property p_ignore_exit;
		@(posedge clock) disable iff (rst)
		(state_reg == deep_sleep_exit_pkg::st_exit && !psel) |=> $stable(wake_reg);
	endproperty
	a_ignore_exit: assert property (p_ignore_exit)
		else $error("wake flag changed during exit");
	property p_core_reset;
		@(posedge clock) disable iff (rst)
		(sleeping && |wake_next) |=> ##1 core_reset [*4];
	endproperty
	a_core_reset: assert property (p_core_reset)
		else $error("core reset not held on exit");
	property p_master_clear_pin;
		@(posedge clock) disable iff (rst)
		(sleeping && !wake_in.master_clear_pin_n) |=> state_reg == deep_sleep_exit_pkg::st_exit;
	endproperty
	a_master_clear_pin: assert property (p_master_clear_pin)
		else $error("master clear did not wake");
	property p_alarm_gate;
		@(posedge clock) disable iff (rst)
		(sleeping && !ctrl_reg[deep_sleep_exit_pkg::calendar_enable_bit] && !psel)
		|=> !wake_reg[deep_sleep_exit_pkg::wake_alarm_bit] || $past(wake_reg[deep_sleep_exit_pkg::wake_alarm_bit]);
	endproperty
	a_alarm_gate: assert property (p_alarm_gate)
		else $error("alarm woke with calendar disabled");
	property p_freeze;
		@(posedge clock) disable iff (rst)
		(frozen && !psel) |=> $stable(pin_out) && $stable(pin_oe);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("pins changed while frozen");
	property p_wake_clear;
		@(posedge clock) disable iff (rst)
		(wr && paddr == deep_sleep_exit_pkg::ctrl_offset && pwdata[deep_sleep_exit_pkg::arm_bit]) |=> wake_reg == '0;
	endproperty
	a_wake_clear: assert property (p_wake_clear)
		else $error("wake flags not cleared on arm");
endmodule // deep_sleep_exit_control
`default_nettype wire

// ### verilog/deep_sleep_exit_pkg.sv
// Package with constants and types for the deep sleep exit controller.
`default_nettype none
package deep_sleep_exit_pkg;
	// Register byte offsets.
	localparam logic [11:0] ctrl_offset = 12'h000;
	localparam logic [11:0] wake_offset = 12'h004;
	localparam logic [11:0] reset_ctrl_offset = 12'h008;
	localparam logic [11:0] scratch0_offset = 12'h00c;
	localparam logic [11:0] scratch1_offset = 12'h010;
	localparam logic [11:0] pin_dir_offset = 12'h014;
	localparam logic [11:0] pin_lat_offset = 12'h018;
	localparam logic [11:0] status_offset = 12'h01c;
	// Control register fields.
	localparam int arm_bit = 15;
	localparam int brownout_bit = 1;
	localparam int unfreeze_bit = 0;
	localparam int calendar_enable_bit = 2;
	localparam int external_interrupt_zero_enable_bit = 3;
	localparam int external_interrupt_zero_polarity_bit = 4;
	localparam int secondary_oscillator_enable_bit = 5;
	localparam int sleep_cmd_bit = 6;
	// Reset control field.
	localparam int exit_flag_bit = 10;
	// Wake source flag positions.
	localparam int wake_por_bit = 0;
	localparam int wake_wdt_bit = 1;
	localparam int wake_alarm_bit = 2;
	localparam int wake_master_clear_pin_bit = 3;
	localparam int wake_external_interrupt_zero_bit = 4;
	localparam int wake_width = 5;
	localparam int pin_count = 16;
	// Arm window and reset sequence length.
	localparam int arm_window_cycles = 3;
	localparam int reset_seq_ns = 1000;
	localparam int clock_period_ns = 25;
	localparam int reset_seq_cycles = (reset_seq_ns + clock_period_ns - 1) / clock_period_ns;
	localparam logic [31:0] zero_word = 32'h00000000;
	typedef enum logic [3:0] {
		st_run = 4'h1,
		st_sleep = 4'h2,
		st_exit = 4'h4,
		st_frozen = 4'h8
	} state_type;
	typedef struct packed {
		logic por;
		logic wdt_timeout;
		logic alarm;
		logic master_clear_pin_n;
		logic external_interrupt_zero_level;
		logic brownout;
	} wake_in_type;
endpackage
`default_nettype wire
